//--- rtl/supervisor_pkg.sv
// Purpose: Shared constants and types of the system reset supervisor
// Assumes: core_clk at 250 MHz
// Notes: Times are given in ns, cycle counts derive from them
package supervisor_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int T_FILTER_NS = 1000;
  localparam int T_SHORT_NS = 10000;
  localparam int T_LONG_NS = 100000;
  // Least times round up
  localparam int FILTER_CYC = (T_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_CYC = (T_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int LONG_CYC = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  localparam int HOLDOFF_W = 3;

  // ****************************************
  // Operating state codes and reset values
  // ****************************************
  localparam logic [1:0] MC_STANDBY = 2'h0;
  localparam logic [1:0] MC_SLEEP = 2'h1;
  localparam logic [1:0] MC_NORMAL_V2OFF = 2'h2;
  localparam logic [1:0] MC_NORMAL = 2'h3;
  localparam int MC_NORMAL_BIT = 1;
  localparam logic POWER_UP_RST = 1'h1;

  typedef enum logic [4:0] {
    MODE_OFF = 5'h01,
    MODE_STANDBY = 5'h02,
    MODE_NORMAL = 5'h04,
    MODE_SLEEP = 5'h08,
    MODE_OVERTEMP = 5'h10
  } mode_t;

  // Asynchronous analog comparator and pin levels
  typedef struct packed {
    logic bat_below_poff;
    logic bat_above_pon;
    logic overtemp_hot;
    logic v1_below_90;
    logic v1_below_70;
    logic v2_below_90;
    logic pullup_present;
    logic guard_disable_pin;
    logic reset_line_n;
  } pins_t;

  // Register-port writes, one-cycle strobes from the serial port logic
  typedef struct packed {
    logic mc_wr;
    logic [1:0] mc_val;
    logic enc_wr;
    logic enc_val;
    logic wmc_wr;
    logic wmc_val;
    logic soft_restart_bit;
    logic fallback_warning_bit_clr;
    logic lhc_clr;
    logic v1_flag_clr;
    logic v2_flag_clr;
    logic pu_flag_clr;
    logic ci_clr;
  } ctrl_wr_t;

  // Watchdog timer events, one-cycle pulses
  typedef struct packed {
    logic window_overflow;
    logic early_trigger;
    logic timeout_overflow;
  } wd_evt_t;

  typedef struct packed {
    logic [1:0] operating_state_field;
    logic gate_output_control;
    logic guard_mode_bit;
    logic fallback_warning_bit;
    logic fallback_active_bit;
    logic v1_low_warn_flag;
    logic v2_low_warn_flag;
    logic power_up_flag;
    logic guard_overflow_irq_flag;
    logic v1_health_bit;
    logic v2_health_bit;
  } status_t;

endpackage : supervisor_pkg

//--- rtl/level_sync.sv
// Purpose: Two-stage synchroniser for a vector of levels
// Assumes: Each bit is an independent level
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk, // Clock
  input wire logic reset, // Synchronous reset
  input wire logic [WIDTH-1:0] async_in, // Levels from outside
  input wire logic [WIDTH-1:0] rst_val, // Constant value under reset
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : level_sync
`default_nettype wire

//--- rtl/reset_pulse_gen.sv
// Purpose: Reset pulse timer that merges overlapping requests
// Assumes: Lengths fit in the counter width
// Notes: A request never shortens a pulse already running
`timescale 1ns/1ps
`default_nettype none
module reset_pulse_gen
  import supervisor_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset, // Synchronous reset
  input wire logic start, // Request, may repeat while active
  input wire logic [CNT_W-1:0] length, // Requested pulse length
  output logic active // Pulse running
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire logic load = start && (length > cnt_q);

  assign cnt_d = load ? length : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
  assign active = (cnt_q != '0);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : reset_pulse_gen
`default_nettype wire

//--- rtl/system_reset_supervisor.sv
// Purpose: System reset, fail-safe gate and fallback alarm controller
// Assumes: Analog comparators and pins arrive asynchronously; register writes,
//   watchdog events and the interrupt line come from logic on core_clk
// Notes: Reset line and fallback alarm are open-drain, enable low drives low
// Behaviour
// R01: Filtered external low on reset line resets
// R02: Internal resets drive low pulse on line
// R03: Undervoltage/Off/Overtemp: pull-up picks short, else long
// R04: All other sources give short pulse; the code drives no pulse after a filtered external low (R01)
// R05: Watchdog faults cause system reset
// R06: Illegal sleep entry resets instead
// R07: Soft restart bit write resets
// R08: Timeout overflow sets flag, no reset; the code resets on an overflow that finds the flag already set
// R09: V1 trip level selectable, health readable
// R10: V1 warning flag at ninety percent
// R11: V2 warning flag at ninety percent
// R12: V2 health real only in Normal
// R13: Gate high only with control and Normal
// R14: Gate control writable in Normal, Standby
// R15: Any reset forces gate low
// R16: Reset sets warning; repeat sets fallback
// R17: Fallback alarm active-low open drain
// R18: Overtemp holds fallback; software may clear
// R19: Software should clear warning after reset
// R20: Battery drives Off; leaving sets power-up flag
// R21: Leaving Overtemp triggers reset
// R22: Operating state switches V2 regulator
// R23: Flags clear on writing one
// R24: Normal is codes ten and eleven
// R25: Simultaneous sources merge, long wins
`timescale 1ns/1ps
`default_nettype none
module system_reset_supervisor
  import supervisor_pkg::*;
#(
  parameter int LONG_PULSE_CYC = LONG_CYC
) (
  input wire logic core_clk, // 250 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire supervisor_pkg::pins_t pins, // Asynchronous pins
  input wire supervisor_pkg::ctrl_wr_t ctrl_wr, // Register writes
  input wire supervisor_pkg::wd_evt_t wd_evt, // Watchdog events
  input wire logic v1_trip_level_sel, // 1 selects 70 percent trip
  input wire logic [4:0] sleep_wake_ctrl, // Five sleep and wake bits
  input wire logic wake_pending, // A wake-up is pending
  input wire logic irq_line_n, // Interrupt line level
  output logic reset_line_out, // Reset line drive value
  output logic reset_line_oe_n, // Reset line enable, low drives
  output logic gate_out, // Fail-safe gate output
  output logic fallback_alarm_out, // Fallback alarm drive value
  output logic fallback_alarm_oe_n, // Fallback alarm enable, low drives
  output logic v2_enable, // V2 regulator on
  output supervisor_pkg::mode_t mode, // Device mode
  output supervisor_pkg::status_t status, // Readable status
  output logic sys_reset_evt // One-cycle system reset event
);
  import supervisor_pkg::*;

  // ****************************************
  // Input synchronisation
  // ****************************************
  localparam pins_t PINS_RST = '{bat_below_poff: 1'h1, reset_line_n: 1'h1,
                                 guard_disable_pin: 1'h0, default: 1'h0};
  pins_t pin_s;

  level_sync #(.WIDTH($bits(pins_t))) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(pins),
    .rst_val(PINS_RST),
    .sync_out(pin_s)
  );

  // ****************************************
  // State
  // ****************************************
  mode_t mode_q, mode_d;
  logic [1:0] mc_q, mc_d;
  logic enc_q, enc_d, wmc_q, wmc_d;
  logic fallback_warning_bit_q, fallback_warning_bit_d, lhc_q, lhc_d;
  logic v1f_q, v1f_d, v2f_q, v2f_d, puf_q, puf_d, ci_q, ci_d;
  logic gdp_q, gate_q, gate_d;
  logic [CNT_W-1:0] flt_q, flt_d;
  logic ext_done_q, ext_done_d;
  logic [HOLDOFF_W-1:0] drv_hist_q;
  logic pulse_active;

  // ****************************************
  // Mode and reset sources
  // ****************************************
  wire logic is_normal = (mode_q == MODE_NORMAL);
  wire logic is_standby = (mode_q == MODE_STANDBY);
  wire logic mc_is_normal = mc_q[MC_NORMAL_BIT]; // R24
  wire logic leave_off = (mode_q == MODE_OFF) && !pin_s.bat_below_poff
                         && pin_s.bat_above_pon; // R20
  wire logic leave_otp = (mode_q == MODE_OVERTEMP) && !pin_s.bat_below_poff
                         && !pin_s.overtemp_hot; // R21
  wire logic v1_uv = v1_trip_level_sel ? pin_s.v1_below_70
                                       : pin_s.v1_below_90; // R09
  wire logic powered = (mode_q != MODE_OFF);
  wire logic sleep_bad = (!irq_line_n || wake_pending
                          || (sleep_wake_ctrl == '0)); // R06
  wire logic sleep_reset = ctrl_wr.mc_wr && (ctrl_wr.mc_val == MC_SLEEP)
                           && sleep_bad && powered; // R06
  wire logic wd_reset = wd_evt.window_overflow || wd_evt.early_trigger
                        || (wd_evt.timeout_overflow && ci_q); // R05
  wire logic wmc_reset = is_normal && ctrl_wr.wmc_wr
                         && (ctrl_wr.wmc_val != wmc_q); // R05
  wire logic gdp_reset = (is_normal || is_standby)
                         && (pin_s.guard_disable_pin != gdp_q); // R05
  wire logic long_src = (powered && v1_uv) || leave_off || leave_otp; // R03 R21
  wire logic short_src = powered && (wd_reset || wmc_reset || gdp_reset
                         || sleep_reset || ctrl_wr.soft_restart_bit); // R04 R07
  wire logic int_req = long_src || short_src; // R25
  // Long only if an undervoltage-type source wants it and no pull-up sits there
  wire logic want_long = long_src && !pin_s.pullup_present; // R03 R25
  wire logic [CNT_W-1:0] pulse_len = want_long ? CNT_W'(LONG_PULSE_CYC)
                                               : CNT_W'(SHORT_CYC); // R04

  reset_pulse_gen u_pulse (
    .core_clk(core_clk),
    .reset(reset),
    .start(int_req),
    .length(pulse_len),
    .active(pulse_active)
  );

  // ****************************************
  // External reset filter
  // ****************************************
  // Our own pulse and its synchroniser echo must not look like an external reset
  wire logic self_drive = pulse_active || (drv_hist_q != '0);
  wire logic ext_low = !pin_s.reset_line_n && !self_drive && powered;
  wire logic ext_evt = ext_low && !ext_done_q
                       && (flt_q == CNT_W'(FILTER_CYC - 1)); // R01
  assign flt_d = !ext_low ? '0 : (flt_q == CNT_W'(FILTER_CYC - 1)) ? flt_q
                 : flt_q + 1'b1;
  assign ext_done_d = ext_low && (ext_done_q || ext_evt);

  assign sys_reset_evt = (int_req && !pulse_active) || ext_evt; // R25

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    mode_d = mode_q;
    mc_d = mc_q;
    enc_d = enc_q;
    wmc_d = wmc_q;
    if (ctrl_wr.mc_wr && !sleep_reset) begin
      mc_d = ctrl_wr.mc_val;
    end
    if (ctrl_wr.wmc_wr) begin
      wmc_d = ctrl_wr.wmc_val;
    end
    if (ctrl_wr.enc_wr && (is_normal || is_standby)) begin
      enc_d = ctrl_wr.enc_val; // R14
    end
    if (sys_reset_evt) begin
      enc_d = 1'b0; // R15
      mc_d = MC_STANDBY;
    end
    if (pin_s.bat_below_poff) begin
      mode_d = MODE_OFF; // R20
      mc_d = MC_STANDBY;
      enc_d = 1'b0;
    end else if (leave_off || leave_otp) begin
      mode_d = MODE_STANDBY; // R20 R21
      mc_d = MC_STANDBY;
    end else if (mode_q == MODE_OFF || mode_q == MODE_OVERTEMP) begin
      mode_d = mode_q;
    end else if (pin_s.overtemp_hot) begin
      mode_d = MODE_OVERTEMP;
      enc_d = 1'b0;
    end else if (mc_d[MC_NORMAL_BIT]) begin
      mode_d = MODE_NORMAL; // R24
    end else if (mc_d == MC_SLEEP) begin
      mode_d = MODE_SLEEP;
    end else begin
      mode_d = MODE_STANDBY;
    end
  end

  // Sticky flags: a set in the same cycle as the clear wins; only for ci_q does ci_clr win over a timeout overflow that finds it set
  assign v1f_d = (powered && pin_s.v1_below_90) || (v1f_q && !ctrl_wr.v1_flag_clr); // R10 R23
  assign v2f_d = (powered && pin_s.v2_below_90) || (v2f_q && !ctrl_wr.v2_flag_clr); // R11 R23
  assign puf_d = leave_off || (puf_q && !ctrl_wr.pu_flag_clr); // R20 R23
  assign ci_d = (wd_evt.timeout_overflow && !ci_q && powered)
                || (ci_q && !ctrl_wr.ci_clr); // R08 R23
  assign fallback_warning_bit_d = sys_reset_evt || (fallback_warning_bit_q && !ctrl_wr.fallback_warning_bit_clr); // R16 R19
  assign lhc_d = (sys_reset_evt && fallback_warning_bit_q) || (mode_d == MODE_OVERTEMP)
                 || (lhc_q && !ctrl_wr.lhc_clr); // R16 R18
  assign gate_d = enc_d && mc_d[MC_NORMAL_BIT] && !sys_reset_evt
                  && (mode_d == MODE_NORMAL); // R13 R15

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= MODE_OFF;
      mc_q <= MC_STANDBY;
      {enc_q, wmc_q, fallback_warning_bit_q, lhc_q, gate_q} <= '0;
      {v1f_q, v2f_q, ci_q, gdp_q, ext_done_q} <= '0;
      puf_q <= POWER_UP_RST;
      flt_q <= '0;
      drv_hist_q <= '0;
    end else begin
      mode_q <= mode_d;
      mc_q <= mc_d;
      {enc_q, wmc_q, fallback_warning_bit_q, lhc_q, gate_q} <= {enc_d, wmc_d, fallback_warning_bit_d, lhc_d, gate_d};
      {v1f_q, v2f_q, puf_q, ci_q} <= {v1f_d, v2f_d, puf_d, ci_d};
      gdp_q <= pin_s.guard_disable_pin;
      ext_done_q <= ext_done_d;
      flt_q <= flt_d;
      drv_hist_q <= {drv_hist_q[HOLDOFF_W-2:0], pulse_active};
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reset_line_out = 1'b0;
  assign reset_line_oe_n = !pulse_active; // R02
  assign fallback_alarm_out = 1'b0;
  assign fallback_alarm_oe_n = !lhc_q; // R17
  assign gate_out = gate_q;
  // Code ten leaves V2 off so an outside source can feed it; monitoring stays on
  assign v2_enable = is_normal && (mc_q == MC_NORMAL); // R22
  assign mode = mode_q;
  assign status = '{
    operating_state_field: mc_q,
    gate_output_control: enc_q,
    guard_mode_bit: wmc_q,
    fallback_warning_bit: fallback_warning_bit_q,
    fallback_active_bit: lhc_q,
    v1_low_warn_flag: v1f_q,
    v2_low_warn_flag: v2f_q,
    power_up_flag: puf_q,
    guard_overflow_irq_flag: ci_q,
    v1_health_bit: !v1_uv, // R09
    v2_health_bit: is_normal ? !pin_s.v2_below_90 : 1'b1 // R12
  };

  // ****************************************
  // Assertions
  // ****************************************
  logic [CNT_W-1:0] drv_len_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      drv_len_q <= '0;
    end else begin
      drv_len_q <= pulse_active ? drv_len_q + 1'b1 : '0;
    end
  end

  property p_gate;
    @(posedge core_clk) disable iff (reset) gate_out |-> enc_q && mc_is_normal;
  endproperty
  a_gate: assert property (p_gate) else $error("gate high without control"); // R13

  property p_gate_rst;
    @(posedge core_clk) disable iff (reset) sys_reset_evt |=> !gate_out;
  endproperty
  a_gate_rst: assert property (p_gate_rst) else $error("gate high after reset"); // R15

  property p_drive;
    @(posedge core_clk) disable iff (reset)
      short_src |=> !reset_line_oe_n [*2];
  endproperty
  a_drive: assert property (p_drive) else $error("internal reset not driven"); // R02

  property p_len;
    @(posedge core_clk) disable iff (reset)
      $fell(pulse_active) |-> (drv_len_q >= CNT_W'(SHORT_CYC));
  endproperty
  a_len: assert property (p_len) else $error("reset pulse too short"); // R04

  property p_warn;
    @(posedge core_clk) disable iff (reset) sys_reset_evt |=> fallback_warning_bit_q;
  endproperty
  a_warn: assert property (p_warn) else $error("warning bit not set"); // R16

  property p_fallback;
    @(posedge core_clk) disable iff (reset)
      sys_reset_evt && fallback_warning_bit_q |=> !fallback_alarm_oe_n;
  endproperty
  a_fallback: assert property (p_fallback) else $error("alarm not raised"); // R16

  property p_ci;
    @(posedge core_clk) disable iff (reset)
      wd_evt.timeout_overflow && !ci_q && powered |=> ci_q;
  endproperty
  a_ci: assert property (p_ci) else $error("overflow flag not set"); // R08

  property p_v2h;
    @(posedge core_clk) disable iff (reset) !is_normal |-> status.v2_health_bit;
  endproperty
  a_v2h: assert property (p_v2h) else $error("v2 health low outside normal"); // R12

  property p_off;
    @(posedge core_clk) disable iff (reset)
      pin_s.bat_below_poff |=> mode == MODE_OFF ##1 1'b1;
  endproperty
  a_off: assert property (p_off) else $error("off mode not entered"); // R20

  property p_otp;
    @(posedge core_clk) disable iff (reset)
      mode == MODE_OVERTEMP |-> !fallback_alarm_oe_n;
  endproperty
  a_otp: assert property (p_otp) else $error("alarm released in overtemp"); // R18

endmodule : system_reset_supervisor
`default_nettype wire

//--- tb/host_mcu_model.sv
// Purpose: Host side of the reset line and the fallback alarm wire
// Assumes: Both wires are open drain with pull-ups, so a released wire reads high
// Notes: The host only ever pulls the reset line low, never drives it high
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input wire logic core_clk, // Clock
  input wire logic dev_rst_out, // Device reset line drive value
  input wire logic dev_rst_oe_n, // Device reset line enable, low drives
  input wire logic alarm_out, // Fallback alarm drive value
  input wire logic alarm_oe_n, // Fallback alarm enable, low drives
  output logic reset_line_n, // Resolved reset line level
  output logic alarm_line_n // Resolved fallback alarm level
);
  logic host_pull_q = 1'b0;

  // ****************************************
  // Wired levels
  // ****************************************
  // Reset line is the wired-and of both parties, alarm line has only the device; pull-up wins when nobody drives
  assign reset_line_n = ((!dev_rst_oe_n && !dev_rst_out) || host_pull_q) ? 1'b0 : 1'b1;
  assign alarm_line_n = (!alarm_oe_n && !alarm_out) ? 1'b0 : 1'b1;

  // Short holds probe the filter, long holds pass it
  task automatic pull_reset(input int cycles);
    repeat (cycles) @(negedge core_clk) host_pull_q = 1'b1;
    @(negedge core_clk) host_pull_q = 1'b0;
  endtask : pull_reset
endmodule : host_mcu_model
`default_nettype wire

//--- tb/test_system_reset_supervisor.sv
// Purpose: Self-checking bench of the system reset supervisor
// Assumes: Long pulse shortened to 3000 cycles
// Notes: Pulse lengths and fallback bits come from a small model kept here
`timescale 1ns/1ps
`default_nettype none
module test_system_reset_supervisor;
  import supervisor_pkg::*;
  localparam int LONG_P = 3000;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  pins_t pin_drv;
  pins_t pins;
  ctrl_wr_t ctrl_wr;
  wd_evt_t wd_evt;
  logic v1_trip_level_sel, wake_pending, irq_line_n;
  logic [4:0] sleep_wake_ctrl;
  logic reset_line_out, reset_line_oe_n, gate_out, fallback_alarm_out, fallback_alarm_oe_n;
  logic v2_enable, sys_reset_evt, line_n, alarm_line_n;
  mode_t mode;
  status_t status;
  int fails = 0;
  int cmp_count = 0;
  int evt_n = 0;
  int seed = 2;
  int m_warn = 0;
  int m_act = 0;
  int run = 0;
  int last_run = 0;

  always #2 core_clk = ~core_clk;
  // Counted on falling edges, where the event has settled
  always @(negedge core_clk) if (sys_reset_evt === 1'b1) evt_n++;
  // Run length of the driven reset pulse, counted on falling edges
  always @(negedge core_clk) begin
    if (reset_line_oe_n === 1'b0) run++;
    else if (run > 0) begin
      last_run = run;
      run = 0;
    end
  end
  always_comb begin
    pins = pin_drv;
    pins.reset_line_n = line_n;
  end

  system_reset_supervisor #(.LONG_PULSE_CYC(LONG_P)) system_reset_supervisor_inst (
    .core_clk(core_clk), .reset(reset), .pins(pins), .ctrl_wr(ctrl_wr), .wd_evt(wd_evt),
    .v1_trip_level_sel(v1_trip_level_sel), .sleep_wake_ctrl(sleep_wake_ctrl),
    .wake_pending(wake_pending), .irq_line_n(irq_line_n), .reset_line_out(reset_line_out),
    .reset_line_oe_n(reset_line_oe_n), .gate_out(gate_out),
    .fallback_alarm_out(fallback_alarm_out), .fallback_alarm_oe_n(fallback_alarm_oe_n),
    .v2_enable(v2_enable), .mode(mode), .status(status), .sys_reset_evt(sys_reset_evt));

  host_mcu_model host_mcu_model_inst (
    .core_clk(core_clk), .dev_rst_out(reset_line_out), .dev_rst_oe_n(reset_line_oe_n),
    .alarm_out(fallback_alarm_out), .alarm_oe_n(fallback_alarm_oe_n),
    .reset_line_n(line_n), .alarm_line_n(alarm_line_n));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input int exp, input logic [31:0] got);
    cmp_count++;
    if (got !== 32'(exp)) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Strobes last one cycle; the extra cycle lets registered status settle
  task automatic hit(input ctrl_wr_t w, input wd_evt_t e = '0);
    ctrl_wr = w;
    wd_evt = e;
    @(negedge core_clk);
    ctrl_wr = '0;
    wd_evt = '0;
    @(negedge core_clk);
  endtask : hit

  task automatic note_reset;
    if (m_warn != 0) m_act = 1;
    m_warn = 1;
    chk("gate", 0, gate_out);
    chk("gate control", 0, status.gate_output_control);
    chk("state field", MC_STANDBY, status.operating_state_field);
    chk("warning", m_warn, status.fallback_warning_bit);
    chk("fallback", m_act, status.fallback_active_bit);
    chk("alarm line", (m_act == 0), alarm_line_n);
  endtask : note_reset

  task automatic pulse(input int lo, input int hi);
    int w;
    w = 0;
    while (last_run == 0 && w < 40000) begin
      @(posedge core_clk);
      w++;
    end
    cmp_count++;
    if (last_run < lo || last_run > hi) begin
      fails++;
      $display("wrong value pulse length expected %0d seen %0d", lo, last_run);
    end
    if (w >= 40000) stop_test();
    last_run = 0;
    @(negedge core_clk);
    note_reset();
  endtask : pulse

  initial begin
    #400000;
    fails++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    pin_drv = '0;
    pin_drv.bat_below_poff = 1'b1;
    ctrl_wr = '0;
    wd_evt = '0;
    v1_trip_level_sel = 1'b0;
    sleep_wake_ctrl = 5'h1f;
    wake_pending = 1'b0;
    irq_line_n = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("mode", MODE_OFF, mode);
    reset = 1'b0;
    pin_drv.bat_below_poff = 1'b0;
    pin_drv.bat_above_pon = 1'b1;
    pulse(LONG_P, LONG_P);
    chk("power-up flag", 1, status.power_up_flag);
    chk("mode", MODE_STANDBY, mode);
    hit(ctrl_wr_t'{pu_flag_clr: 1'b1, fallback_warning_bit_clr: 1'b1, default: '0});
    m_warn = 0;
    chk("power-up flag", 0, status.power_up_flag);
    for (int i = 0; i < 8; i++) begin
      irq_line_n = (i != 5);
      wake_pending = (i == 6);
      sleep_wake_ctrl = (i == 7) ? 5'h00 : (5'($random(seed)) | 5'h01);
      case (i)
        0: hit(ctrl_wr_t'{soft_restart_bit: 1'b1, default: '0});
        1: hit('0, wd_evt_t'{window_overflow: 1'b1, default: '0});
        2: hit('0, wd_evt_t'{early_trigger: 1'b1, default: '0});
        3: pin_drv.guard_disable_pin = !pin_drv.guard_disable_pin;
        4: begin
          hit(ctrl_wr_t'{mc_wr: 1'b1, mc_val: MC_NORMAL, default: '0});
          hit(ctrl_wr_t'{wmc_wr: 1'b1, wmc_val: !status.guard_mode_bit, default: '0});
        end
        default: hit(ctrl_wr_t'{mc_wr: 1'b1, mc_val: MC_SLEEP, default: '0});
      endcase
      pulse(SHORT_CYC, SHORT_CYC);
    end
    hit(ctrl_wr_t'{lhc_clr: 1'b1, fallback_warning_bit_clr: 1'b1, default: '0});
    m_warn = 0;
    m_act = 0;
    chk("alarm line", 1, alarm_line_n);
    hit('0, wd_evt_t'{timeout_overflow: 1'b1, default: '0});
    chk("timeout flag", 1, status.guard_overflow_irq_flag);
    chk("no pulse", 1, reset_line_oe_n);
    hit('0, wd_evt_t'{timeout_overflow: 1'b1, default: '0});
    pulse(SHORT_CYC, SHORT_CYC);
    hit(ctrl_wr_t'{ci_clr: 1'b1, default: '0});
    chk("timeout flag", 0, status.guard_overflow_irq_flag);
    pin_drv.v2_below_90 = 1'b1;
    hit(ctrl_wr_t'{enc_wr: 1'b1, enc_val: 1'b1, default: '0});
    chk("gate", 0, gate_out);
    hit(ctrl_wr_t'{mc_wr: 1'b1, mc_val: MC_NORMAL_V2OFF, default: '0});
    chk("mode", MODE_NORMAL, mode);
    chk("gate", 1, gate_out);
    chk("v2 enable", 0, v2_enable);
    hit(ctrl_wr_t'{mc_wr: 1'b1, mc_val: MC_NORMAL, default: '0});
    chk("v2 enable", 1, v2_enable);
    chk("v2 health", 0, status.v2_health_bit);
    chk("v2 flag", 1, status.v2_low_warn_flag);
    pin_drv.v2_below_90 = 1'b0;
    hit(ctrl_wr_t'{soft_restart_bit: 1'b1, default: '0});
    pulse(SHORT_CYC, SHORT_CYC);
    chk("v2 health", 1, status.v2_health_bit);
    hit(ctrl_wr_t'{v2_flag_clr: 1'b1, default: '0});
    chk("v2 flag", 0, status.v2_low_warn_flag);
    // Below the warning level but above the 70 percent trip: flag only
    pin_drv.pullup_present = 1'b1;
    v1_trip_level_sel = 1'b1;
    pin_drv.v1_below_90 = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("no pulse", 1, reset_line_oe_n);
    chk("v1 flag", 1, status.v1_low_warn_flag);
    chk("v1 health", 1, status.v1_health_bit);
    v1_trip_level_sel = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("v1 health", 0, status.v1_health_bit);
    pin_drv.v1_below_90 = 1'b0;
    pulse(SHORT_CYC, SHORT_CYC + 8);
    hit(ctrl_wr_t'{v1_flag_clr: 1'b1, default: '0});
    chk("v1 flag", 0, status.v1_low_warn_flag);
    evt_n = 0;
    host_mcu_model_inst.pull_reset(100);
    repeat (4) @(negedge core_clk);
    chk("short low", 0, evt_n);
    host_mcu_model_inst.pull_reset(300);
    repeat (4) @(negedge core_clk);
    chk("external reset", 1, evt_n);
    chk("line released", 1, reset_line_oe_n);
    note_reset();
    pin_drv.pullup_present = 1'b0;
    pin_drv.overtemp_hot = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("mode", MODE_OVERTEMP, mode);
    hit(ctrl_wr_t'{lhc_clr: 1'b1, default: '0});
    chk("fallback held", 1, status.fallback_active_bit);
    m_act = 1;
    pin_drv.overtemp_hot = 1'b0;
    pulse(LONG_P, LONG_P);
    hit(ctrl_wr_t'{lhc_clr: 1'b1, fallback_warning_bit_clr: 1'b1, default: '0});
    chk("alarm line", 1, alarm_line_n);
    pin_drv.bat_below_poff = 1'b1;
    pin_drv.bat_above_pon = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("mode", MODE_OFF, mode);
    stop_test();
  end
endmodule : test_system_reset_supervisor
`default_nettype wire
